//--- pdn_map.vh
// Register map, field layout, reset values and timing constants of the done/near block
// Function
// - Flag internal command done when command zero
// - Assert done when selected condition holds
// - Assert near using near threshold condition
// - Unit select picks encoder or command deviation
// - Condition 0: deviation below threshold only
// - Condition 1: also filtered command zero
// - Condition 2: also unfiltered command zero
// - Condition 3: done held minimum hold time
// - Hold time zero holds until next command
// - Servo disabled forces done and near low
// - Done threshold 1 to 65535, low while moving
// - Near threshold default 65535, low until met
`ifndef PDN_MAP_VH
`define PDN_MAP_VH

// Register byte offsets
`define PDN_OFF_CTRL      12'h000
`define PDN_OFF_DONE_THR  12'h004
`define PDN_OFF_NEAR_THR  12'h008
`define PDN_OFF_WINDOW    12'h00C
`define PDN_OFF_HOLD      12'h010
`define PDN_OFF_STATUS    12'h014
`define PDN_OFF_IRQ_STAT  12'h018
`define PDN_OFF_IRQ_MASK  12'h01C

// Control register fields
`define PDN_CTRL_COND_LSB 0
`define PDN_CTRL_COND_MSB 1
`define PDN_CTRL_UNIT_BIT 2

// Reset values
`define PDN_RST_COND      2'h0
`define PDN_RST_UNIT      1'h0
`define PDN_RST_DONE_THR  16'h02DE
`define PDN_RST_NEAR_THR  16'hFFFF
`define PDN_RST_WINDOW    15'h0000
`define PDN_RST_HOLD      15'h0000
`define PDN_RST_MASK      3'h0

// Timing: the ms tick derives from a 25 ns clock
`define PDN_CLK_PERIOD_NS 25
`define PDN_MS_NS         1000000
`define PDN_MS_CYCLES     (`PDN_MS_NS / `PDN_CLK_PERIOD_NS)

// Output condition codes
`define PDN_COND_PLAIN    2'h0
`define PDN_COND_FILT     2'h1
`define PDN_COND_RAW      2'h2
`define PDN_COND_HOLD     2'h3

`endif

//--- pdn_ms_timer.v
// Millisecond countdown timer with start, abort and expiry flag
module pdn_ms_timer #(
    parameter MS_CYCLES = 40000,
    parameter CNT_W     = 15
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             tick,
    input  wire             start,
    input  wire             abort,
    input  wire [CNT_W-1:0] load,
    output reg              running,
    output reg              expired
);
    reg [CNT_W-1:0] remain;

    // Count down one unit per millisecond tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain  <= {CNT_W{1'b0}};
            running <= 1'b0;
            expired <= 1'b0;
        end else if (abort) begin
            remain  <= {CNT_W{1'b0}};
            running <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            remain  <= load;
            running <= (load != {CNT_W{1'b0}});
            expired <= (load == {CNT_W{1'b0}});
        end else if (running && tick) begin
            // Expire on the tick after zero: the first tick may come at once, so N ms spans N+1 ticks
            if (remain == {CNT_W{1'b0}}) begin
                running <= 1'b0;
                expired <= 1'b1;
            end else begin
                remain <= remain - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // pdn_ms_timer

//--- pdn_done_near.v
// Positioning done / near detector with APB registers and interrupt
`include "pdn_map.vh"
module pdn_done_near #(
    parameter MS_CYCLES = `PDN_MS_CYCLES,
    parameter DEV_W     = 32
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire             servo_enable,
    input  wire             position_mode,
    input  wire [DEV_W-1:0] deviation_enc,
    input  wire [DEV_W-1:0] deviation_cmd,
    input  wire             cmd_filtered_zero,
    input  wire             cmd_raw_zero,
    input  wire             internal_cmd_zero,
    output reg              internal_cmd_done,
    output reg              position_done,
    output reg              position_near,
    output reg              irq
);
    // Hold and window counters and condition state
    localparam ST_IDLE  = 4'b0001;
    localparam ST_WIN   = 4'b0010;
    localparam ST_DONE  = 4'b0100;
    localparam ST_HOLD  = 4'b1000;

    reg  [1:0]       done_near_condition;
    reg              deviation_unit_select;
    reg  [15:0]      done_threshold;
    reg  [15:0]      near_threshold;
    reg  [14:0]      done_window_time;
    reg  [14:0]      done_hold_time;
    reg  [2:0]       irq_status;
    reg  [2:0]       irq_mask;
    reg  [3:0]       state;
    reg  [3:0]       next_state;
    reg  [31:0]      ms_count;
    reg              ms_tick;
    reg              prev_done;
    reg              prev_near;
    reg              prev_cmd;
    reg              raw_cmd_zero_d;
    reg              win_start;
    reg              hold_start;
    reg              tmr_start;
    reg              tmr_abort;
    reg  [14:0]      tmr_load;
    reg  [DEV_W-1:0] abs_dev;
    reg              cmd_ok;
    reg              done_cond;
    reg              near_cond;
    reg              active;
    reg              next_done;
    wire             tmr_running;
    wire             tmr_expired;
    wire [DEV_W-1:0] dev_sel;
    wire             new_cmd;
    wire             apb_acc;
    wire             rd_stat;
    wire [2:0]       ev;

    // Unit select picks the deviation source
    assign dev_sel = deviation_unit_select ? deviation_cmd : deviation_enc;
    // Command edge from zero to nonzero marks the next command
    assign new_cmd = raw_cmd_zero_d & ~cmd_raw_zero;
    assign apb_acc = psel & penable & ~pready;
    assign rd_stat = apb_acc & ~pwrite & (paddr == `PDN_OFF_IRQ_STAT);

    // Absolute deviation and the condition qualifiers
    always @* begin
        abs_dev = dev_sel[DEV_W-1] ? (~dev_sel + {{(DEV_W-1){1'b0}}, 1'b1}) : dev_sel;
        case (done_near_condition)
            `PDN_COND_PLAIN: cmd_ok = 1'b1;
            `PDN_COND_FILT:  cmd_ok = cmd_filtered_zero;
            `PDN_COND_RAW:   cmd_ok = cmd_raw_zero;
            `PDN_COND_HOLD:  cmd_ok = cmd_filtered_zero;
            default:         cmd_ok = 1'b0;
        endcase
        active    = servo_enable & position_mode;
        // Strictly below threshold; threshold zero is never met
        done_cond = active & cmd_ok & (abs_dev < {{(DEV_W-16){1'b0}}, done_threshold});
        near_cond = active & cmd_ok & (abs_dev < {{(DEV_W-16){1'b0}}, near_threshold});
    end

    // Millisecond tick shared by window and hold timing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_count <= 32'h00000000;
            ms_tick  <= 1'b0;
        end else if (ms_count >= MS_CYCLES - 1) begin
            ms_count <= 32'h00000000;
            ms_tick  <= 1'b1;
        end else begin
            ms_count <= ms_count + 32'h00000001;
            ms_tick  <= 1'b0;
        end
    end

    pdn_ms_timer #(
        .MS_CYCLES (MS_CYCLES),
        .CNT_W     (15)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick),
        .start   (tmr_start),
        .abort   (tmr_abort),
        .load    (tmr_load),
        .running (tmr_running),
        .expired (tmr_expired)
    );

    // Done sequencing: window filter, then optional hold
    always @* begin
        next_state = state;
        next_done  = 1'b0;
        win_start  = 1'b0;
        hold_start = 1'b0;
        case (state)
            ST_IDLE: begin
                if (done_cond) begin
                    win_start  = 1'b1;
                    next_state = ST_WIN;
                end
            end
            ST_WIN: begin
                if (!done_cond) begin
                    next_state = ST_IDLE;                      // Condition broke, restart window
                end else if (tmr_expired) begin
                    next_done  = 1'b1;
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_done = 1'b1;
                if (!active) begin
                    next_done  = 1'b0;
                    next_state = ST_IDLE;
                end else if (done_near_condition == `PDN_COND_HOLD) begin
                    hold_start = 1'b1;
                    next_state = ST_HOLD;
                end else if (!done_cond) begin
                    next_done  = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                next_done = 1'b1;
                if (!active) begin
                    next_done  = 1'b0;
                    next_state = ST_IDLE;
                end else if (done_hold_time == 15'h0000) begin
                    if (new_cmd) begin
                        next_done  = 1'b0;
                        next_state = ST_IDLE;
                    end
                end else if (tmr_expired && !done_cond) begin
                    next_done  = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        tmr_start = win_start | hold_start;
        tmr_abort = (state == ST_WIN) & ~done_cond;
        tmr_load  = hold_start ? done_hold_time : done_window_time;
    end

    // Outputs, each from a flip-flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= ST_IDLE;
            position_done     <= 1'b0;
            position_near     <= 1'b0;
            internal_cmd_done <= 1'b0;
            raw_cmd_zero_d    <= 1'b1;
        end else begin
            state             <= next_state;
            position_done     <= next_done & active;
            position_near     <= near_cond;
            internal_cmd_done <= internal_cmd_zero;
            raw_cmd_zero_d    <= cmd_raw_zero;
        end
    end

    // Event edges feed sticky status bits
    assign ev = {~prev_cmd & internal_cmd_done, ~prev_near & position_near, ~prev_done & position_done};

    // APB slave, one wait state, read of interrupt status clears it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= 32'h00000000;
            done_near_condition   <= `PDN_RST_COND;
            deviation_unit_select <= `PDN_RST_UNIT;
            done_threshold        <= `PDN_RST_DONE_THR;
            near_threshold        <= `PDN_RST_NEAR_THR;
            done_window_time      <= `PDN_RST_WINDOW;
            done_hold_time        <= `PDN_RST_HOLD;
            irq_status            <= 3'h0;
            irq_mask              <= `PDN_RST_MASK;
            irq                   <= 1'b0;
            prev_done             <= 1'b0;
            prev_near             <= 1'b0;
            prev_cmd              <= 1'b0;
        end else begin
            prev_done <= position_done;
            prev_near <= position_near;
            prev_cmd  <= internal_cmd_done;
            pready    <= apb_acc;
            pslverr   <= 1'b0;
            // Set beats read clear so no event is lost
            irq_status <= (rd_stat ? 3'h0 : irq_status) | ev;
            irq        <= |(irq_status & irq_mask);
            if (apb_acc) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `PDN_OFF_CTRL: begin
                        if (pwrite) begin
                            done_near_condition   <= pwdata[`PDN_CTRL_COND_MSB:`PDN_CTRL_COND_LSB];
                            deviation_unit_select <= pwdata[`PDN_CTRL_UNIT_BIT];
                        end
                        prdata <= {29'h0, deviation_unit_select, done_near_condition};
                    end
                    `PDN_OFF_DONE_THR: begin
                        // Zero is outside the legal range and is ignored
                        if (pwrite && pwdata[15:0] != 16'h0000)
                            done_threshold <= pwdata[15:0];
                        prdata <= {16'h0, done_threshold};
                    end
                    `PDN_OFF_NEAR_THR: begin
                        if (pwrite && pwdata[15:0] != 16'h0000)
                            near_threshold <= pwdata[15:0];
                        prdata <= {16'h0, near_threshold};
                    end
                    `PDN_OFF_WINDOW: begin
                        if (pwrite)
                            done_window_time <= pwdata[14:0];
                        prdata <= {17'h0, done_window_time};
                    end
                    `PDN_OFF_HOLD: begin
                        if (pwrite)
                            done_hold_time <= pwdata[14:0];
                        prdata <= {17'h0, done_hold_time};
                    end
                    `PDN_OFF_STATUS:   prdata <= {29'h0, internal_cmd_done, position_near, position_done};
                    `PDN_OFF_IRQ_STAT: prdata <= {29'h0, irq_status};
                    `PDN_OFF_IRQ_MASK: begin
                        if (pwrite)
                            irq_mask <= pwdata[2:0];
                        prdata <= {29'h0, irq_mask};
                    end
                    default: pslverr <= 1'b1;                  // Unmapped address
                endcase
            end
        end
    end
endmodule // pdn_done_near

//--- pdn_host_model.sv
// Host controller model that takes the three status outputs and watches only position_done
module pdn_host_model (
    input  wire pclk,
    input  wire position_done,
    input  wire position_near,
    input  wire internal_cmd_done,
    output int  done_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_done = 1'b0;
    int   count     = 0;
    // Host counts completed moves on each rising done edge
    always @(posedge pclk) begin
        last_done <= position_done;
        if (position_done && !last_done)
            count <= count + 1;
    end
    assign done_edges = count;
endmodule // pdn_host_model

//--- pdn_done_near_properties.sv
// Port-level assertions of the done/near block
module pdn_done_near_properties (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire servo_enable,
    input wire position_mode,
    input wire internal_cmd_zero,
    input wire internal_cmd_done,
    input wire position_done,
    input wire position_near
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Status outputs follow their causes with fixed latency
    cmd_done_follow_a: assert property (1'b1 |=> internal_cmd_done == $past(internal_cmd_zero))
        else $error("internal cmd done does not follow its input");
    servo_off_clear_a: assert property (!servo_enable |=> !position_done && !position_near)
        else $error("done or near high with servo off");
    mode_off_clear_a: assert property (!position_mode |=> !position_done && !position_near)
        else $error("done or near high outside position control");
    near_cause_a: assert property ($rose(position_near) |-> $past(servo_enable) && $past(position_mode))
        else $error("near rose without servo on in position control");
    done_cause_a: assert property ($rose(position_done) |-> $past(servo_enable, 2) && $past(position_mode, 2))
        else $error("done rose too early after enable");
    // Bus answer shape: one-cycle ready, error only with ready
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle into access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
endmodule // pdn_done_near_properties

bind pdn_done_near pdn_done_near_properties u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .servo_enable, .position_mode, .internal_cmd_zero, .internal_cmd_done, .position_done, .position_near);

//--- pdn_done_near_tb.sv
// Self-checking testbench of the done/near block
`include "pdn_map.vh"
module pdn_done_near_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, dev_enc = 32'h0, dev_cmd = 32'h0, rd;
    logic        pready, pslverr, servo = 0, pmode = 1, filt = 1, raw = 1, icz = 0;
    logic        cmd_done, done, near, irq;
    int          n_errors = 0, checked = 0, seen;
    logic [11:0] ra [6] = '{`PDN_OFF_CTRL, `PDN_OFF_DONE_THR, `PDN_OFF_NEAR_THR, `PDN_OFF_WINDOW,
                            `PDN_OFF_HOLD, `PDN_OFF_IRQ_MASK};
    logic [31:0] rv [6] = '{32'h0, 32'h2DE, 32'hFFFF, 32'h0, 32'h0, 32'h0};

    pdn_done_near #(.MS_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_enable(servo), .position_mode(pmode), .deviation_enc(dev_enc), .deviation_cmd(dev_cmd),
        .cmd_filtered_zero(filt), .cmd_raw_zero(raw), .internal_cmd_zero(icz), .internal_cmd_done(cmd_done),
        .position_done(done), .position_near(near), .irq(irq));
    pdn_host_model host (.pclk(pclk), .position_done(done), .position_near(near), .internal_cmd_done(cmd_done),
        .done_edges(seen));

    initial forever #12.5 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Setup then access phase, held until pready seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic cond(input logic [1:0] m, input logic f, input logic r);
        return m == `PDN_COND_PLAIN ? 1'b1 : (m == `PDN_COND_RAW ? r : f);
    endfunction

    // Outputs read after n+1 edges, at the last edge before the design updates them
    task automatic wait_chk(input int n, input logic d, input logic nr);
        repeat (n + 1) @(posedge pclk);
        check(done, d);
        check(near, nr);
    endtask

    // Servo off clears history, then one fresh settle with given magnitude
    task automatic trial(input logic [1:0] m, input logic u, input logic [31:0] mag, input logic fix = 1'b0);
        logic [31:0] v;
        logic c;
        apb(1'b1, `PDN_OFF_CTRL, {29'h0, u, m});
        servo <= 1'b0;
        repeat (2) @(posedge pclk);
        v = $urandom_range(1) ? -mag : mag;
        filt <= fix || ($urandom_range(1) != 0);
        raw <= fix || ($urandom_range(1) != 0);
        pmode <= fix || ($urandom_range(7) != 0);
        icz <= $urandom_range(1);
        dev_enc <= u ? 32'd5000 : v;
        dev_cmd <= u ? v : 32'd5000;
        servo <= 1'b1;
        @(posedge pclk);
        c = cond(m, filt, raw) & pmode;
        wait_chk(6, c && mag < 100, c && mag < 1000);
    endtask

    task automatic stop_test;
        $display("checks=%0d errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h74CB));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, rv[i]);
        end
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b1, `PDN_OFF_DONE_THR, 32'd100);
        apb(1'b1, `PDN_OFF_NEAR_THR, 32'd1000);
        // Threshold edges in every mode, then random traffic
        for (int m = 0; m < 4; m++) begin
            trial(m, m[0], 32'd99);
            trial(m, m[1], 32'd100);
            trial(m, 1'b0, 32'd999);
            trial(m, 1'b1, 32'd1000);
        end
        for (int i = 0; i < 32; i++) trial($urandom_range(3), $urandom_range(1), $urandom_range(1199));
        check(irq, 1'b0);
        check(seen > 0, 1'b1);
        // Hold mode with zero hold: held until the next command
        pmode <= 1'b1;
        filt <= 1'b1;
        raw <= 1'b1;
        trial(`PDN_COND_HOLD, 1'b0, 32'd10, 1'b1);
        dev_enc <= 32'd5000;
        wait_chk(6, 1'b1, 1'b0);
        raw <= 1'b0;
        wait_chk(4, 1'b0, 1'b0);
        // Timed hold of 2 ms then release once condition gone
        apb(1'b1, `PDN_OFF_HOLD, 32'd2);
        raw <= 1'b1;
        trial(`PDN_COND_HOLD, 1'b0, 32'd10, 1'b1);
        dev_enc <= 32'd5000;
        wait_chk(3, 1'b1, 1'b0);
        wait_chk(20, 1'b0, 1'b0);
        // Window of 2 ms delays done, interrupt unmasked on done
        apb(1'b0, `PDN_OFF_IRQ_STAT, 32'h0);
        apb(1'b1, `PDN_OFF_IRQ_MASK, 32'h1);
        apb(1'b1, `PDN_OFF_WINDOW, 32'd2);
        servo <= 1'b0;
        apb(1'b1, `PDN_OFF_CTRL, 32'h0);
        dev_enc <= 32'd5;
        servo <= 1'b1;
        wait_chk(4, 1'b0, 1'b1);
        wait_chk(20, 1'b1, 1'b1);
        check(irq, 1'b1);
        apb(1'b0, `PDN_OFF_IRQ_STAT, 32'h0);
        check(rd[0], 1'b1);
        repeat (4) @(posedge pclk);
        check(irq, 1'b0);
        stop_test();
    end

    initial begin
        #200us;
        n_errors++;
        stop_test();
    end
endmodule // pdn_done_near_tb
